// ### src/otp_ctl_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef OTP_CTL_PARAMS_SVH
`define OTP_CTL_PARAMS_SVH

`define OFS_TRIGGER 6'h00
`define OFS_VLIMIT 6'h04
`define OFS_EVENT 6'h08
`define OFS_STATUS 6'h0C
`define OFS_IRQ_MASK 6'h10
`define OFS_CMD_ADDR 6'h14
`define OFS_WDATA 6'h18
`define OFS_RDATA 6'h1C
`define OFS_DATA_SEL 6'h20
`define OFS_ERR_CNT 6'h24
`define OFS_PROTECT 6'h28
`define OFS_CMD_SEL 6'h2C

`define TRIG_START_BIT 0
`define VLIMIT_W 14
`define VLIMIT_RST 14'h03D0
`define EV_DONE 7
`define EV_STAT 6
`define EV_VPP 5
`define EV_PAFAIL 3
`define EV_EMPTY 2
`define EV_LDFAIL 1
`define EV_CRC 0
`define EV_MASK_USED 8'hEF
`define ST_BUSY 7
`define ST_STAT 6
`define ST_VMON 5
`define ST_PWRUP 4
`define BYTE_EN_RST 4'hF
`define ERR_CNT_MAX 4'hF
`define CMD_ADDR_W 11

// Monitor unit time and the derived cycle count at 250 MHz
`define VMON_UNIT_US 1024
`define CLK_MHZ 250
`define VMON_UNIT_CYC (`VMON_UNIT_US * `CLK_MHZ)

// Sequencer phase counter loads; each phase lasts its load plus one clock cycle, power-up recovery also until the power-up pin is high
`define SETUP_CYC 8'h04
`define PULSE_CYC 8'h10
`define HOLD_CYC 8'h04
`define RECOV_CYC 8'h04
`define PWRUP_CYC 8'h08

`endif

// ### src/otp_ctl_pkg.sv
// Types shared by the controller and its sequencer
package otp_ctl_pkg;
  typedef enum logic [2:0] {
    ST_RESET, ST_PWR_REC, ST_RST_REC, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOV
  } fsm_e;
  typedef logic [7:0] byte_t;
endpackage

// ### src/otp_seq_if.sv
// Handshake between the register front end and the command sequencer
interface otp_seq_if;
  logic start;
  logic done;
  logic busy;
  logic [2:0] code;
  modport ctl(output start, input done, input busy, input code);
  modport seq(input start, output done, output busy, output code);
endinterface

// ### src/otp_seq.sv
// Command sequencer driving the memory macro through setup, pulse, hold, recovery
`include "otp_ctl_params.svh"
module otp_seq (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic mem_pwr_up, // Macro power-up pin
  otp_seq_if.seq sq, // Start and completion handshake
  output logic mem_strobe // Macro access pulse
);
  import otp_ctl_pkg::*;

  fsm_e state_q;
  fsm_e state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic cnt_zero;

  assign cnt_zero = (cnt_q == 8'h00);

  // State codes are fixed by the status field layout
  function automatic logic [2:0] code_of(input fsm_e s);
    case (s)
      ST_RESET: code_of = 3'h0;
      ST_PWR_REC: code_of = 3'h1;
      ST_RST_REC: code_of = 3'h2;
      ST_IDLE: code_of = 3'h4;
      ST_SETUP: code_of = 3'h5;
      ST_PULSE: code_of = 3'h7;
      ST_HOLD: code_of = 3'h3;
      ST_RECOV: code_of = 3'h6;
      default: code_of = 3'h0;
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? 8'h00 : cnt_q - 8'h01;
    case (state_q)
      ST_RESET: begin
        state_d = ST_PWR_REC;
        cnt_d = `PWRUP_CYC;
      end
      ST_PWR_REC: begin
        if (cnt_zero && mem_pwr_up) begin
          state_d = ST_RST_REC;
          cnt_d = `RECOV_CYC;
        end
      end
      ST_RST_REC: begin
        if (cnt_zero) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sq.start) begin
          state_d = ST_SETUP;
          cnt_d = `SETUP_CYC;
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_d = ST_PULSE;
          cnt_d = `PULSE_CYC;
        end
      end
      ST_PULSE: begin
        if (cnt_zero) begin
          state_d = ST_HOLD;
          cnt_d = `HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          state_d = ST_RECOV;
          cnt_d = `RECOV_CYC;
        end
      end
      ST_RECOV: begin
        if (cnt_zero) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign sq.code = code_of(state_q);
  assign sq.busy = (state_q == ST_SETUP) || (state_q == ST_PULSE) ||
                   (state_q == ST_HOLD) || (state_q == ST_RECOV);
  assign sq.done = (state_q == ST_RECOV) && cnt_zero;
  assign mem_strobe = (state_q == ST_PULSE);
endmodule

// ### src/otp_manual_ctl.sv
// Manual command control and status registers of the one-time programmable memory controller
// What this block does
// - Writing one to start bit launches the set-up manual command; bit reads zero.
// - While access protection is on, start writes are ignored.
// - 14-bit limit field, reset 0x3D0, sets monitor periods before error.
// - One limit unit equals 1024 us of monitor time.
// - Event bit 7 sets when a manual request completes; write one clears.
// - Event bit 6 latches high status pin; re-sets at once if still high.
// - Event bit 5 sets on pump idle overrun; stays set while condition persists.
// - Event bit 3 sets on program-assist failure; write one clears.
// - Event bit 2 sets on empty configuration load; write one clears.
// - Event bit 1 sets on startup load failure; write one clears.
// - Event bit 0 sets on startup CRC errors; write one clears.
// - Status bit 7 is high from request start to finish.
// - Status bits 6 and 5 show live status pin and live monitor flag.
// - Status bit 4 shows live power-up pin.
// - Status bits 2:0 report the control state machine state code.
// - 4-bit byte enable, reset all ones, used only by program assist.
// - 4-bit CRC error counter increments, saturates, writable by software.
//
// Our own choices: the Avalon-MM slave port and the address map.
`include "otp_ctl_params.svh"
module otp_manual_ctl (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [1:0] avs_response, // 00 ok, 10 slave error
  output logic irq, // Level interrupt
  input wire logic mem_status, // Macro status pin
  input wire logic mem_pwr_up, // Macro power-up pin
  input wire logic voltage_watch_signal, // Pump activity monitor flag
  input wire logic mon_tick, // One-cycle pulse per monitor clock period
  input wire logic pa_fail, // Program-assist failure pulse
  input wire logic load_empty, // Empty configuration pulse
  input wire logic load_fail, // Startup load failure pulse
  input wire logic crc_err, // Loader CRC error pulse
  input wire logic [31:0] mem_rdata, // Macro selected read bus
  output logic mem_strobe, // Access pulse to macro
  output logic [10:0] mem_addr, // Command address
  output logic [31:0] mem_wdata, // Command write data
  output logic [3:0] mem_byte_en, // Program-assist byte enable
  output logic [2:0] mem_cmd, // Command code
  output logic [2:0] mem_rdata_sel, // Read bus select
  output logic vpp_timeout // Monitor limit exceeded
);
  import otp_ctl_pkg::*;

  otp_seq_if sq();

  logic [13:0] vlimit_q;
  logic [7:0] event_q;
  logic [7:0] event_d;
  logic [7:0] mask_q;
  logic [10:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [3:0] byte_en_q;
  logic [2:0] rsel_q;
  logic [3:0] err_cnt_q;
  logic protect_q;
  logic [2:0] cmd_q;
  logic [17:0] unit_cnt_q;
  logic [13:0] idle_cnt_q;
  logic vto_q;
  logic ack_q;
  logic [31:0] rd_q;
  logic [1:0] resp_q;

  // One-cycle answer: waitrequest high on the first cycle of each request
  wire req = (avs_read || avs_write) && !ack_q;
  // Writes land only at the edge that samples waitrequest low
  wire wr = avs_write && ack_q;
  wire rd = avs_read && !ack_q;
  wire hit_trig = (avs_address == `OFS_TRIGGER);
  wire hit_vlim = (avs_address == `OFS_VLIMIT);
  wire hit_evt = (avs_address == `OFS_EVENT);
  wire hit_sts = (avs_address == `OFS_STATUS);
  wire hit_mask = (avs_address == `OFS_IRQ_MASK);
  wire hit_addr = (avs_address == `OFS_CMD_ADDR);
  wire hit_wdat = (avs_address == `OFS_WDATA);
  wire hit_rdat = (avs_address == `OFS_RDATA);
  wire hit_dsel = (avs_address == `OFS_DATA_SEL);
  wire hit_ecnt = (avs_address == `OFS_ERR_CNT);
  wire hit_prot = (avs_address == `OFS_PROTECT);
  wire hit_csel = (avs_address == `OFS_CMD_SEL);
  wire mapped = hit_trig | hit_vlim | hit_evt | hit_sts | hit_mask | hit_addr |
                hit_wdat | hit_rdat | hit_dsel | hit_ecnt | hit_prot | hit_csel;
  wire lane0 = avs_byteenable[0];
  wire lane1 = avs_byteenable[1];

  // Merge write data into a register honouring byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  wire start_req = wr && hit_trig && lane0 && avs_writedata[`TRIG_START_BIT];
  // Protected or already running: the strobe is dropped
  assign sq.start = start_req && !protect_q && !sq.busy;

  // Monitor time base: one limit unit of 1024 us, counted in ref_clk cycles
  wire unit_end = (unit_cnt_q == 18'(`VMON_UNIT_CYC - 1));
  wire [13:0] vlimit_wr = avs_writedata[13:0];
  wire over_limit = (idle_cnt_q >= vlimit_q);
  wire [31:0] vlim_merged = merge({18'h0_0000, vlimit_q}, {18'h0_0000, vlimit_wr},
                                  avs_byteenable);
  wire [31:0] addr_merged = merge({21'h00_0000, addr_q}, avs_writedata, avs_byteenable);

  wire [7:0] w1c = (wr && hit_evt && lane0) ? avs_writedata[7:0] : 8'h00;
  wire [7:0] ev_set = {sq.done,
                       mem_status,
                       vto_q,
                       1'b0,
                       pa_fail,
                       load_empty,
                       load_fail,
                       crc_err};
  // Set wins over clear so a coincident event is never lost
  assign event_d = ((event_q & ~w1c) | ev_set) & `EV_MASK_USED;

  wire [7:0] sts = {sq.busy,
                    mem_status, voltage_watch_signal,
                    mem_pwr_up,
                    1'b0, sq.code};

  wire [31:0] rmux =
      hit_vlim ? {18'h0_0000, vlimit_q} :
      hit_evt ? {24'h00_0000, event_q} :
      hit_sts ? {24'h00_0000, sts} :
      hit_mask ? {24'h00_0000, mask_q} :
      hit_addr ? {21'h00_0000, addr_q} :
      hit_wdat ? wdata_q :
      hit_rdat ? rdata_q :
      hit_dsel ? {24'h00_0000, byte_en_q, 1'b0, rsel_q} :
      hit_ecnt ? {28'h000_0000, err_cnt_q} :
      hit_prot ? {31'h0000_0000, protect_q} :
      hit_csel ? {29'h0000_0000, cmd_q} :
      32'h0000_0000; // start bit always reads zero

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else begin
      ack_q <= req;
      rd_q <= rd ? rmux : rd_q;
      resp_q <= req ? (mapped ? 2'h0 : 2'h2) : resp_q;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rd_q;
  assign avs_response = resp_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_q <= 8'h00;
    end else begin
      event_q <= event_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vlimit_q <= `VLIMIT_RST;
      mask_q <= 8'h00;
      addr_q <= 11'h000;
      wdata_q <= 32'h0000_0000;
      rsel_q <= 3'h0;
      protect_q <= 1'b0;
      cmd_q <= 3'h0;
    end else begin
      if (wr && hit_vlim) vlimit_q <= vlim_merged[13:0];
      if (wr && hit_mask && lane0) mask_q <= avs_writedata[7:0];
      if (wr && hit_addr) addr_q <= addr_merged[10:0];
      if (wr && hit_wdat) wdata_q <= merge(wdata_q, avs_writedata, avs_byteenable);
      if (wr && hit_dsel && lane0) rsel_q <= avs_writedata[2:0];
      if (wr && hit_prot && lane0) protect_q <= avs_writedata[0];
      if (wr && hit_csel && lane0) cmd_q <= avs_writedata[2:0];
    end
  end

  // Byte enable is reset to all lanes and only reaches the macro for program assist
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_en_q <= `BYTE_EN_RST;
    end else if (wr && hit_dsel && lane0) begin
      byte_en_q <= avs_writedata[7:4];
    end
  end

  // Software write takes priority over a loader increment in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_cnt_q <= 4'h0;
    end else if (wr && hit_ecnt && lane0) begin
      err_cnt_q <= avs_writedata[3:0];
    end else if (crc_err && err_cnt_q != `ERR_CNT_MAX) begin
      err_cnt_q <= err_cnt_q + 4'h1;
    end
  end

  // Read data captured from the macro when the command completes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (sq.done) begin
      rdata_q <= mem_rdata;
    end
  end

  // Idle time of the pump, in limit units; cleared whenever the pump is active
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_cnt_q <= 18'h0_0000;
      idle_cnt_q <= 14'h0000;
      vto_q <= 1'b0;
    end else begin
      unit_cnt_q <= (!voltage_watch_signal || unit_end) ? 18'h0_0000 : unit_cnt_q + 18'h0_0001;
      if (!voltage_watch_signal) begin
        idle_cnt_q <= 14'h0000;
      end else if (mon_tick && unit_end && !over_limit) begin
        idle_cnt_q <= idle_cnt_q + 14'h0001;
      end
      vto_q <= voltage_watch_signal && over_limit;
    end
  end

  otp_seq u_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .mem_pwr_up(mem_pwr_up),
    .sq(sq.seq),
    .mem_strobe(mem_strobe)
  );

  // Busy drops as the sequencer leaves recovery, the same edge done sets the flag
  assign irq = |(event_q & mask_q);
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign mem_byte_en = (cmd_q == 3'h2) ? byte_en_q : 4'h0;
  assign mem_cmd = cmd_q;
  assign mem_rdata_sel = rsel_q;
  assign vpp_timeout = vto_q;
endmodule

// ### tb/otp_manual_ctl_monitor.sv
// Assertion checker for the manual command controller, bound to its ports
`include "otp_ctl_params.svh"
module otp_manual_ctl_monitor (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic [5:0] avs_address, // Bus address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic mem_status, // Status pin
  input wire logic mem_pwr_up, // Power-up pin
  input wire logic voltage_watch_signal, // Monitor flag
  input wire logic mem_strobe, // Access pulse
  input wire logic [2:0] mem_cmd, // Command code
  input wire logic [3:0] mem_byte_en, // Byte enable
  input wire logic vpp_timeout // Limit exceeded
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] on_q;
  logic [7:0] since_q;
  wire logic start_w = avs_write && !avs_waitrequest && avs_address == `OFS_TRIGGER
    && avs_writedata[0];
  wire logic stat_rd = avs_read && !avs_waitrequest && avs_address == `OFS_STATUS;
  // Saturates so a long idle gap never wraps back into the accepted window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_q <= 8'h00;
      since_q <= 8'hFF;
    end else begin
      on_q <= mem_strobe ? on_q + 8'h01 : 8'h00;
      since_q <= start_w ? 8'h00 : (since_q == 8'hFF ? 8'hFF : since_q + 8'h01);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  one_wait_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  start_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address == `OFS_TRIGGER |-> !avs_readdata[0])
    else $error("start bit read back as one");
  strobe_cause_a: assert property (
    $rose(mem_strobe) |-> since_q inside {[4:6]})
    else $error("access pulse without a preceding start write");
  pulse_len_a: assert property (
    $fell(mem_strobe) |-> on_q == 8'h11)
    else $error("access pulse length wrong");
  pulse_state_a: assert property (
    stat_rd && $past(mem_strobe) |-> avs_readdata[7] && avs_readdata[2:0] == 3'h7)
    else $error("status during pulse not busy with pulse code");
  live_pins_a: assert property (
    stat_rd |-> avs_readdata[6:5] == {$past(mem_status), $past(voltage_watch_signal)})
    else $error("status does not show live pin levels");
  pwr_pin_a: assert property (
    stat_rd |-> avs_readdata[4] == $past(mem_pwr_up))
    else $error("status does not show power-up pin");
  be_gate_a: assert property (
    mem_cmd != 3'h2 |-> mem_byte_en == 4'h0)
    else $error("byte enable driven for a command other than program assist");
  vpp_cause_a: assert property (
    $rose(vpp_timeout) |-> $past(voltage_watch_signal))
    else $error("voltage timeout without monitor flag");
endmodule

bind otp_manual_ctl otp_manual_ctl_monitor u_mon (.ref_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_status, .mem_pwr_up,
  .voltage_watch_signal, .mem_strobe, .mem_cmd, .mem_byte_en, .vpp_timeout);

// ### tb/otp_macro_model.sv
// Behavioural model of the memory macro facing the controller
module otp_macro_model (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic mem_strobe, // Access pulse
  input wire logic [10:0] mem_addr, // Command address
  input wire logic [2:0] mem_cmd, // Command code
  output logic mem_pwr_up, // Power-up pin
  output logic [31:0] mem_rdata // Read bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wake_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_q <= 5'h00;
      mem_pwr_up <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      // Power comes up late so the boot wait is really exercised
      if (wake_q != 5'h1F) wake_q <= wake_q + 5'h01;
      mem_pwr_up <= wake_q == 5'h1F;
      if (mem_strobe && mem_cmd == 3'h0) mem_rdata <= {21'h0, mem_addr} ^ 32'h5A5A_0000;
      else if (mem_strobe) mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ### tb/test_otp_manual_command_status.sv
// Self-checking bench for the manual command control and status block
`include "otp_ctl_params.svh"
module test_otp_manual_command_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic mem_status = 1'b0;
  logic vmon = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [31:0] avs_readdata, mem_rdata, rv, d, mem_wdata, w;
  logic [1:0] avs_response, rp;
  logic avs_waitrequest, irq, mem_pwr_up, mem_strobe, vpp_timeout;
  logic [10:0] mem_addr, a;
  logic [2:0] mem_cmd, mem_rdata_sel, r;
  logic [3:0] mem_byte_en, be;
  int fail_count = 0;
  int num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  otp_manual_ctl u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .irq(irq), .mem_status(mem_status), .mem_pwr_up(mem_pwr_up),
    .voltage_watch_signal(vmon), .mon_tick(1'b1), .pa_fail(ev[3]), .load_empty(ev[2]),
    .load_fail(ev[1]), .crc_err(ev[0]), .mem_rdata(mem_rdata), .mem_strobe(mem_strobe),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_byte_en(mem_byte_en), .mem_cmd(mem_cmd),
    .mem_rdata_sel(mem_rdata_sel), .vpp_timeout(vpp_timeout));
  otp_macro_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem_strobe(mem_strobe),
    .mem_addr(mem_addr), .mem_cmd(mem_cmd), .mem_pwr_up(mem_pwr_up), .mem_rdata(mem_rdata));
  function automatic logic [31:0] st(input logic b, s, v, input logic [2:0] c);
    return {24'h0, b, s, v, 2'b10, c};
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until a rising edge samples waitrequest low; answer taken at that edge
  task automatic xfer(input logic wr, input logic [5:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    rp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0000_0000);
    chk(rv, exp);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 60; i++) begin
      xfer(1'b0, `OFS_STATUS, 32'h0000_0000);
      if ((rv & m) === v) break;
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h5080a7a7));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    poll(32'h0000_0007, 32'h0000_0004);
    rdc(`OFS_VLIMIT, 32'h0000_03D0);
    chk(32'(rp), 32'h0000_0000);
    rdc(`OFS_DATA_SEL, 32'h0000_00F0);
    rdc(`OFS_EVENT, 32'h0000_0000);
    rdc(`OFS_STATUS, st(0, 0, 0, 3'h4));
    rdc(6'h3C, 32'h0000_0000);
    chk(32'(rp), 32'h0000_0002);
    d = $urandom();
    xfer(1'b1, `OFS_VLIMIT, d);
    rdc(`OFS_VLIMIT, d & 32'h0000_3FFF);
    for (int k = 0; k < 3; k++) begin
      a = 11'($urandom());
      be = 4'($urandom());
      xfer(1'b1, `OFS_CMD_ADDR, {21'h0, a});
      w = $urandom();
      r = 3'($urandom());
      xfer(1'b1, `OFS_WDATA, w);
      xfer(1'b1, `OFS_DATA_SEL, {24'h0, be, 1'b0, r});
      xfer(1'b1, `OFS_CMD_SEL, 32'(k));
      xfer(1'b1, `OFS_IRQ_MASK, {24'h0, k == 1, 7'h0});
      chk(32'(mem_byte_en), 32'(k == 2 ? be : 4'h0));
      chk(mem_wdata, w);
      chk(32'(mem_rdata_sel), 32'(r));
      xfer(1'b1, `OFS_TRIGGER, 32'h0000_0001);
      rdc(`OFS_STATUS, st(1, 0, 0, 3'h5));
      poll(32'h0000_0080, 32'h0000_0000);
      rdc(`OFS_EVENT, 32'h0000_0080);
      chk(32'(irq), 32'(k == 1));
      if (k == 0) rdc(`OFS_RDATA, {21'h0, a} ^ 32'h5A5A_0000);
      rdc(`OFS_TRIGGER, 32'h0000_0000);
      xfer(1'b1, `OFS_EVENT, 32'h0000_0080);
      rdc(`OFS_EVENT, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
    end
    xfer(1'b1, `OFS_PROTECT, 32'h0000_0001);
    xfer(1'b1, `OFS_TRIGGER, 32'h0000_0001);
    rdc(`OFS_STATUS, st(0, 0, 0, 3'h4));
    repeat (40) @(posedge ref_clk);
    rdc(`OFS_EVENT, 32'h0000_0000);
    xfer(1'b1, `OFS_PROTECT, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      ev <= 4'(1 << i);
      @(posedge ref_clk);
      ev <= 4'h0;
      rdc(`OFS_EVENT, 32'(1 << i));
      xfer(1'b1, `OFS_EVENT, 32'h0000_000F);
      rdc(`OFS_EVENT, 32'h0000_0000);
    end
    rdc(`OFS_ERR_CNT, 32'h0000_0001);
    ev <= 4'h1;
    repeat (20) @(posedge ref_clk);
    ev <= 4'h0;
    rdc(`OFS_ERR_CNT, 32'h0000_000F);
    xfer(1'b1, `OFS_ERR_CNT, 32'h0000_0005);
    rdc(`OFS_ERR_CNT, 32'h0000_0005);
    xfer(1'b1, `OFS_EVENT, 32'h0000_0001);
    mem_status <= 1'b1;
    rdc(`OFS_STATUS, st(0, 1, 0, 3'h4));
    xfer(1'b1, `OFS_EVENT, 32'h0000_0040);
    rdc(`OFS_EVENT, 32'h0000_0040);
    mem_status <= 1'b0;
    xfer(1'b1, `OFS_EVENT, 32'h0000_0040);
    rdc(`OFS_EVENT, 32'h0000_0000);
    xfer(1'b1, `OFS_VLIMIT, 32'h0000_0001);
    vmon <= 1'b1;
    repeat (2000) @(posedge ref_clk);
    chk(32'(vpp_timeout), 32'h0000_0000);
    xfer(1'b1, `OFS_VLIMIT, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    chk(32'(vpp_timeout), 32'h0000_0001);
    rdc(`OFS_STATUS, st(0, 0, 1, 3'h4));
    xfer(1'b1, `OFS_EVENT, 32'h0000_0020);
    rdc(`OFS_EVENT, 32'h0000_0020);
    vmon <= 1'b0;
    repeat (4) @(posedge ref_clk);
    xfer(1'b1, `OFS_EVENT, 32'h0000_0020);
    rdc(`OFS_EVENT, 32'h0000_0000);
    stop_test();
  end
endmodule
